// ---- hdl/sdp_pkg.sv ----
// Constants and types for the streaming data port handshake block.
// Assumes one core clock; all port pins arrive from outside that domain.
//
// Functional notes
// - One packet-marking sync mode per port; counter-only mode is the reset default.
// - Fixed-length modes take packet length from fixed_block_length.
// - Counter-only read outputs no data unless data_available_flag is active; the lane still drives rbyte_r whenever direction_select is high.
// - With port_enable low, all other port controls are ignored; direction_select still sets lane drive and buffer_select_pins the flag.
// - data_available_flag rises with the first byte driven on the lane.
// - Read advances on the edge that samples port_enable high; lane holds otherwise.
// - First-byte-marker read drives packet_marker during each packet's first byte.
// - With port_enable low and data left, current byte stays on the lane.
// - Last-byte-marker read flags each packet's final byte; data valid when enabled.
// - Serial marker may last one bit or a byte; meaning follows sync mode.
// - Serial bit order programmable both ways; MSB first by default.
// - Counter-only write ignores packet_marker; internal counter finds boundaries.
// - On writes, packet_marker is disregarded while port_enable is low.
// - Last-byte-marker write accepts varying lengths, closing on the marked byte.
// - Multistream: data_available_flag low unless the holding read buffer is addressed.
// - Multistream read: flag, marker and first byte appear in the same cycle.
package sdp_pkg;
   localparam int SDP_BYTE_W = 8;
   localparam int SDP_SEL_W = 3;
   localparam int SDP_LEN_W = 12;
   localparam int SDP_FIFO_DEPTH = 16;
   localparam int SDP_BIT_CNT_W = 3;
   localparam logic [SDP_BIT_CNT_W-1:0] SDP_LAST_BIT = 3'h7;
   localparam logic [SDP_LEN_W-1:0] SDP_LEN_RST = 12'h0BC;

   typedef enum logic [1:0]
   {
      SDP_SYNC_COUNTER,
      SDP_SYNC_FIRST,
      SDP_SYNC_LAST
   } sdp_sync_mode_t;

   localparam sdp_sync_mode_t SDP_SYNC_RST = SDP_SYNC_COUNTER;

   // Pins sampled together through the synchroniser
   typedef struct packed {
      logic pclk;
      logic en;
      logic rw;
      logic [SDP_SEL_W-1:0] sel;
      logic mark;
      logic [SDP_BYTE_W-1:0] data;
   } sdp_pins_t;

   // Byte stored from the port toward the transmit buffers
   typedef struct packed {
      logic [SDP_SEL_W-1:0] buf_num;
      logic first;
      logic last;
      logic [SDP_BYTE_W-1:0] data;
   } sdp_wr_word_t;

   // Byte from the receive buffer toward the port
   typedef struct packed {
      logic last;
      logic [SDP_BYTE_W-1:0] data;
   } sdp_rd_word_t;
endpackage

// ---- hdl/sdp_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and asynchronous active-high reset.
module sdp_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign in_ready = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != '0);
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         case ({push, pop})
            2'b10: count_r <= count_r + 1'b1;
            2'b01: count_r <= count_r - 1'b1;
            default: count_r <= count_r;
         endcase
      end
   end
endmodule

// ---- hdl/sdp_port.sv ----
// Streaming data port handshake: byte-wide or serial, three sync modes.
// Assumes port pins are asynchronous to clk; the port clock is sampled, not used as a clock.
module sdp_port
   import sdp_pkg::*;
#(
   parameter int FIFO_DEPTH = SDP_FIFO_DEPTH,
   parameter int LEN_W = SDP_LEN_W
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic port_clock,
   input wire logic port_enable,
   input wire logic direction_select,
   input wire logic [SDP_SEL_W-1:0] buffer_select_pins,
   input wire logic packet_marker_in,
   input wire logic [SDP_BYTE_W-1:0] byte_lane_in,
   output logic [SDP_BYTE_W-1:0] byte_lane_out,
   output logic byte_lane_oe_n,
   output logic packet_marker_out,
   output logic packet_marker_oe_n,
   output logic data_available_flag,
   output logic buffer_overrun,
   input wire sdp_sync_mode_t sync_mode,
   input wire logic [LEN_W-1:0] fixed_block_length,
   input wire logic multistream_en,
   input wire logic [SDP_SEL_W-1:0] read_buffer_num,
   input wire logic serial_mode,
   input wire logic lsb_first,
   input wire logic serial_marker_byte,
   output logic tx_valid,
   input wire logic tx_ready,
   output sdp_wr_word_t tx_word,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire sdp_rd_word_t rx_word
);
   sdp_pins_t pins_now;
   sdp_pins_t pins_meta_r;
   sdp_pins_t pins_r;
   logic pclk_prev_r;
   logic edge_en;
   logic wr_edge;
   logic rd_edge;
   // Write path state
   logic [SDP_BIT_CNT_W-1:0] wbit_r;
   logic [SDP_BYTE_W-1:0] wshift_r;
   logic wmark_r;
   logic [LEN_W-1:0] wcnt_r;
   logic win_pkt_r;
   logic wbyte_done;
   logic [SDP_BYTE_W-1:0] wbyte;
   logic wmark;
   logic wstore;
   logic wfirst;
   logic wlast;
   logic [LEN_W-1:0] wcnt_nxt;
   logic win_pkt_nxt;
   logic wq_valid;
   logic wq_ready;
   sdp_wr_word_t wq_word;
   // Read path state
   logic rq_valid;
   logic rq_ready;
   sdp_rd_word_t rq_word;
   logic pres_r;
   logic [SDP_BYTE_W-1:0] rbyte_r;
   logic rlast_r;
   logic [LEN_W-1:0] rcnt_r;
   logic [SDP_BIT_CNT_W-1:0] rbit_r;
   logic rsel_ok;
   logic rbyte_done;
   logic rload;
   logic [SDP_BIT_CNT_W-1:0] rbit_idx;
   logic rmark;
   default clocking cb_chk @(posedge clk); endclocking
   default disable iff (rst);

   assign pins_now = '{pclk: port_clock, en: port_enable, rw: direction_select,
                       sel: buffer_select_pins, mark: packet_marker_in, data: byte_lane_in};

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pins_meta_r <= '0;
         pins_r <= '0;
         pclk_prev_r <= 1'b0;
      end
      else
      begin
         pins_meta_r <= pins_now;
         pins_r <= pins_meta_r;
         pclk_prev_r <= pins_r.pclk;
      end
   end

   assign edge_en = pins_r.pclk && !pclk_prev_r && pins_r.en;
   assign wr_edge = edge_en && !pins_r.rw;
   assign rd_edge = edge_en && pins_r.rw;

   assign wbyte_done = !serial_mode || (wbit_r == SDP_LAST_BIT);
   always_comb
   begin
      wbyte = pins_r.data;
      if (serial_mode)
      begin
         wbyte = lsb_first ? {pins_r.data[0], wshift_r[SDP_BYTE_W-1:1]}
                           : {wshift_r[SDP_BYTE_W-2:0], pins_r.data[0]};
      end
   end
   // Marker of one bit or whole byte
   assign wmark = pins_r.mark || (serial_mode && wmark_r);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wbit_r <= '0;
         wshift_r <= '0;
         wmark_r <= 1'b0;
      end
      else if (wr_edge)
      begin
         wbit_r <= wbyte_done ? '0 : wbit_r + 1'b1;
         wshift_r <= wbyte;
         wmark_r <= wbyte_done ? 1'b0 : wmark;
      end
   end

   // Packet boundary tagging on a completed write byte
   always_comb
   begin
      wstore = 1'b1;
      wfirst = 1'b0;
      wlast = 1'b0;
      wcnt_nxt = wcnt_r;
      win_pkt_nxt = win_pkt_r;
      case (sync_mode)
         SDP_SYNC_FIRST:
         begin
            // Marker only counts on enabled bytes
            if (wmark)
            begin
               wfirst = 1'b1;
               wcnt_nxt = LEN_W'(1);
            end
            else
            begin
               wstore = win_pkt_r;
               wcnt_nxt = wcnt_r + 1'b1;
            end
            wlast = wstore && (wcnt_nxt == fixed_block_length);
            win_pkt_nxt = wstore && !wlast;
         end
         SDP_SYNC_LAST:
         begin
            wfirst = !win_pkt_r;
            wlast = wmark;
            win_pkt_nxt = !wmark;
         end
         default:
         begin
            wfirst = (wcnt_r == '0);
            wlast = (wcnt_r + 1'b1 == fixed_block_length);
            wcnt_nxt = wlast ? '0 : wcnt_r + 1'b1;
            win_pkt_nxt = !wlast;
         end
      endcase
   end

   // Enabled bytes go to the buffer, except first-byte-marker bytes outside a packet
   assign wq_valid = wr_edge && wbyte_done && wstore;
   assign wq_word = '{buf_num: pins_r.sel, first: wfirst, last: wlast, data: wbyte};

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wcnt_r <= '0;
         win_pkt_r <= 1'b0;
      end
      else if (wr_edge && wbyte_done)
      begin
         wcnt_r <= wcnt_nxt;
         win_pkt_r <= win_pkt_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         buffer_overrun <= 1'b0;
      end
      else if (wq_valid && !wq_ready)
      begin
         buffer_overrun <= 1'b1;
      end
   end

   sdp_fifo #(.WIDTH($bits(sdp_wr_word_t)), .DEPTH(FIFO_DEPTH)) u_tx_fifo
   (
      .clk(clk),
      .rst(rst),
      .in_valid(wq_valid),
      .in_ready(wq_ready),
      .in_data(wq_word),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_word)
   );
   sdp_fifo #(.WIDTH($bits(sdp_rd_word_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo
   (
      .clk(clk),
      .rst(rst),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data(rx_word),
      .out_valid(rq_valid),
      .out_ready(rq_ready),
      .out_data(rq_word)
   );

   // Only the addressed read buffer presents data
   assign rsel_ok = !multistream_en || (pins_r.sel == read_buffer_num);
   assign rbyte_done = !serial_mode || (rbit_r == SDP_LAST_BIT);
   assign rload = rq_valid && rsel_ok && (!pres_r || (rd_edge && rbyte_done));
   assign rq_ready = rload;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pres_r <= 1'b0;
         rbyte_r <= '0;
         rlast_r <= 1'b0;
         rbit_r <= '0;
      end
      else
      begin
         if (rd_edge && pres_r)
         begin
            rbit_r <= rbyte_done ? '0 : rbit_r + 1'b1;
         end
         if (rload)
         begin
            pres_r <= 1'b1;
            rbyte_r <= rq_word.data;
            rlast_r <= rq_word.last;
         end
         else if (rd_edge && rbyte_done)
         begin
            pres_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rcnt_r <= '0;
      end
      else if (pres_r && rd_edge && rbyte_done)
      begin
         rcnt_r <= (rcnt_r + 1'b1 == fixed_block_length) ? '0 : rcnt_r + 1'b1;
      end
   end

   assign rbit_idx = lsb_first ? rbit_r : SDP_LAST_BIT - rbit_r;
   always_comb
   begin
      case (sync_mode)
         SDP_SYNC_FIRST: rmark = (rcnt_r == '0);
         SDP_SYNC_LAST: rmark = rlast_r;
         default: rmark = 1'b0;
      endcase
      if (serial_mode && !serial_marker_byte && rbit_r != '0)
      begin
         rmark = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         byte_lane_out <= '0;
         byte_lane_oe_n <= 1'b1;
         packet_marker_out <= 1'b0;
         packet_marker_oe_n <= 1'b1;
         data_available_flag <= 1'b0;
      end
      else
      begin
         byte_lane_out <= serial_mode ? {7'h00, rbyte_r[rbit_idx]} : rbyte_r;
         byte_lane_oe_n <= !pins_r.rw;
         packet_marker_out <= pres_r && rmark;
         packet_marker_oe_n <= !(pins_r.rw && sync_mode != SDP_SYNC_COUNTER);
         data_available_flag <= pres_r && rsel_ok;
      end
   end

   // Checks
   property p_flag_follows_pres;
      pres_r && rsel_ok && !serial_mode
      |=> data_available_flag && byte_lane_out == $past(rbyte_r);
   endproperty
   a_flag_follows_pres: assert property (p_flag_follows_pres)
      else $error("flag did not follow presented byte");
   property p_no_data_without_flag;
      !pres_r |=> !data_available_flag;
   endproperty
   a_no_data_without_flag: assert property (p_no_data_without_flag)
      else $error("flag high with nothing presented");
   property p_hold_when_disabled;
      pres_r && !rd_edge |=> $stable(rbyte_r) && pres_r;
   endproperty
   a_hold_when_disabled: assert property (p_hold_when_disabled)
      else $error("byte changed without enabled edge");
   property p_no_store_disabled;
      !pins_r.en |-> !wq_valid && (!rload || !pres_r);
   endproperty
   a_no_store_disabled: assert property (p_no_store_disabled)
      else $error("activity while port disabled");
   property p_ms_select;
      multistream_en && pins_r.sel != read_buffer_num |=> !data_available_flag;
   endproperty
   a_ms_select: assert property (p_ms_select)
      else $error("flag raised for unaddressed buffer");
   property p_first_mark;
      sync_mode == SDP_SYNC_FIRST && !serial_mode && pres_r && rsel_ok && rcnt_r == '0
      |=> packet_marker_out && data_available_flag;
   endproperty
   a_first_mark: assert property (p_first_mark)
      else $error("first byte not marked");
   property p_last_close;
      wq_valid && sync_mode == SDP_SYNC_LAST |-> wq_word.last == wmark;
   endproperty
   a_last_close: assert property (p_last_close)
      else $error("last byte flag mismatch");
   property p_count_close;
      wq_valid && sync_mode == SDP_SYNC_COUNTER && wq_word.last |=> wcnt_r == '0;
   endproperty
   a_count_close: assert property (p_count_close)
      else $error("counter did not restart");
   c_read_byte: cover property (rd_edge && pres_r);
   c_write_byte: cover property (wq_valid && wq_word.last);
   c_overrun: cover property (wq_valid && !wq_ready);
endmodule

// ---- test/sdp_src_model.sv ----
// Model of the external stream source/sink on the port pins.
// Assumes the bench calls its tasks; clk only paces the pin changes.
module sdp_src_model
   import sdp_pkg::*;
(
   input wire logic clk,
   output logic port_clock,
   output logic port_enable,
   output logic direction_select,
   output logic [SDP_SEL_W-1:0] buffer_select_pins,
   output logic packet_marker_in,
   output logic [SDP_BYTE_W-1:0] byte_lane_in,
   input wire logic [SDP_BYTE_W-1:0] byte_lane_out,
   input wire logic packet_marker_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      port_clock = 1'b0;
      port_enable = 1'b0;
      direction_select = 1'b0;
      buffer_select_pins = 3'h0;
      packet_marker_in = 1'b0;
      byte_lane_in = 8'h00;
   end
   task automatic cyc(input logic en, input logic mk, input logic [7:0] d,
         output logic [7:0] q, output logic qm);
      port_enable <= en;
      packet_marker_in <= mk;
      byte_lane_in <= en ? d : ~d;
      repeat (4) @(posedge clk);
      q = byte_lane_out;
      qm = packet_marker_out;
      port_clock <= 1'b1;
      repeat (4) @(posedge clk);
      port_clock <= 1'b0;
   endtask
   task automatic setup(input logic rw, input logic [SDP_SEL_W-1:0] sel);
      logic [7:0] q;
      logic qm;
      direction_select <= rw;
      buffer_select_pins <= sel;
      repeat (2) cyc(1'b0, 1'b0, byte_lane_in, q, qm);
   endtask
   task automatic wr(input logic [7:0] d, input logic mk, input logic ser, input logic lsb);
      logic [7:0] q;
      logic qm;
      if (!ser)
         cyc(1'b1, mk, d, q, qm);
      else
         for (int i = 0; i < 8; i++)
            cyc(1'b1, mk && i == 0, {7'h00, lsb ? d[i] : d[7-i]}, q, qm);
   endtask
   task automatic rd(output logic [7:0] q, output logic qm);
      cyc(1'b1, 1'b0, 8'h00, q, qm);
   endtask
   task automatic idle();
      port_enable <= 1'b0;
      @(posedge clk);
   endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench: writes, reads, multistream, overrun and serial traffic.
// Assumes sdp_pkg, sdp_fifo, sdp_port and sdp_src_model are compiled first.
module tb
   import sdp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic port_clock, port_enable, direction_select, packet_marker_in;
   logic [2:0] buffer_select_pins;
   logic [2:0] read_buffer_num = 3'h5;
   logic [7:0] byte_lane_in, byte_lane_out;
   logic byte_lane_oe_n, packet_marker_out, packet_marker_oe_n, data_available_flag;
   logic buffer_overrun, multistream_en = 1'b0, serial_mode = 1'b0, lsb_first = 1'b0;
   logic serial_marker_byte = 1'b0;
   logic tx_valid, rx_ready, tx_ready = 1'b0, rx_valid = 1'b0;
   sdp_sync_mode_t sync_mode = SDP_SYNC_COUNTER;
   logic [SDP_LEN_W-1:0] fixed_block_length = 12'h003;
   sdp_wr_word_t tx_word;
   sdp_rd_word_t rx_word = '0;
   int error_cnt = 0;
   int n_checks = 0;
   always #20 clk = ~clk;
   sdp_port dut (.clk, .rst, .port_clock, .port_enable, .direction_select,
      .buffer_select_pins, .packet_marker_in, .byte_lane_in, .byte_lane_out,
      .byte_lane_oe_n, .packet_marker_out, .packet_marker_oe_n, .data_available_flag,
      .buffer_overrun, .sync_mode, .fixed_block_length, .multistream_en, .read_buffer_num,
      .serial_mode, .lsb_first, .serial_marker_byte, .tx_valid, .tx_ready, .tx_word,
      .rx_valid, .rx_ready, .rx_word);
   sdp_src_model src (.clk, .port_clock, .port_enable, .direction_select,
      .buffer_select_pins, .packet_marker_in, .byte_lane_in, .byte_lane_out,
      .packet_marker_out);
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic bad(input string msg);
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_checks++;
      if (got !== exp)
         bad(msg);
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      n_checks++;
      if (got !== exp)
         bad(msg);
   endtask
   task automatic wait_hi(ref logic s, input string msg);
      int n;
      for (n = 0; n < 200 && s !== 1'b1; n++)
         @(posedge clk);
      if (s !== 1'b1)
      begin
         bad(msg);
         final_report();
      end
   endtask
   task automatic pop(input logic [7:0] d, input logic f, input logic l,
         input logic [2:0] b, input logic fl);
      wait_hi(tx_valid, "no tx word");
      chk_byte(tx_word.data, d, "tx data");
      if (fl)
      begin
         chk_bit(tx_word.first, f, "tx first");
         chk_bit(tx_word.last, l, "tx last");
         chk_byte({5'h00, tx_word.buf_num}, {5'h00, b}, "tx buffer");
      end
      tx_ready <= 1'b1;
      @(posedge clk);
      tx_ready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic push_n(input int n, input int len);
      int i;
      int k;
      for (i = 0; i < n; i++)
      begin
         rx_valid <= 1'b1;
         rx_word.last <= (i % len) == len - 1;
         rx_word.data <= 8'hA0 + 8'(i);
         for (k = 0; k < 50 && !(k > 0 && rx_ready === 1'b1); k++)
            @(posedge clk);
         if (rx_ready !== 1'b1)
            bad("rx stuck");
      end
      rx_valid <= 1'b0;
   endtask
   task automatic t_write(input sdp_sync_mode_t m, input logic [11:0] len,
         input logic [5:0] mk, input logic [5:0] keep, input logic [5:0] fst,
         input logic [5:0] lst);
      logic [7:0] q;
      logic qm;
      int i;
      sync_mode <= m;
      fixed_block_length <= len;
      src.setup(1'b0, 3'h0);
      for (i = 0; i < 6; i++)
      begin
         src.wr(8'h50 + 8'(i), mk[i], 1'b0, 1'b0);
         if (i == 2)
            src.cyc(1'b0, 1'b1, 8'hEE, q, qm);
      end
      src.idle();
      for (i = 0; i < 6; i++)
         if (keep[i])
            pop(8'h50 + 8'(i), fst[i], lst[i], 3'h0, 1'b1);
   endtask
   task automatic t_read(input sdp_sync_mode_t m);
      logic [7:0] q;
      logic qm;
      int i;
      sync_mode <= m;
      src.setup(1'b1, 3'h0);
      src.rd(q, qm);
      repeat (3) @(posedge clk);
      chk_bit(data_available_flag, 1'b0, "flag when empty"); // no data
      push_n(6, 3);
      wait_hi(data_available_flag, "no flag");
      chk_byte(byte_lane_out, 8'hA0, "first byte"); // byte with flag
      chk_bit(byte_lane_oe_n, 1'b0, "lane not driven");
      for (i = 0; i < 6; i++)
      begin
         if (i == 2)
         begin
            src.cyc(1'b0, 1'b0, 8'h00, q, qm);
            repeat (2) @(posedge clk);
            chk_byte(byte_lane_out, 8'hA2, "byte not held"); // hold
         end
         src.rd(q, qm);
         chk_byte(q, 8'hA0 + 8'(i), "read byte"); // advance per edge
         if (m != SDP_SYNC_COUNTER)
            chk_bit(qm, m == SDP_SYNC_FIRST ? i % 3 == 0 : i % 3 == 2, "marker");
         else
            chk_bit(packet_marker_oe_n, 1'b1, "marker driven");
      end
      repeat (3) @(posedge clk);
      chk_bit(data_available_flag, 1'b0, "flag after drain");
      src.idle();
   endtask
   task automatic t_multi();
      logic [7:0] q;
      logic qm;
      multistream_en <= 1'b1;
      sync_mode <= SDP_SYNC_FIRST;
      fixed_block_length <= 12'h001;
      src.setup(1'b1, 3'h2);
      push_n(1, 1);
      repeat (10) @(posedge clk);
      chk_bit(data_available_flag, 1'b0, "flag wrong buffer"); // other buffer
      src.setup(1'b1, 3'h5);
      wait_hi(data_available_flag, "no flag");
      chk_bit(packet_marker_out, 1'b1, "marker with flag"); // marker with flag
      chk_byte(byte_lane_out, 8'hA0, "byte with flag"); // byte with flag
      src.rd(q, qm);
      repeat (3) @(posedge clk);
      chk_bit(data_available_flag, 1'b0, "flag after read");
      src.idle();
      src.setup(1'b0, 3'h6);
      src.wr(8'h3C, 1'b1, 1'b0, 1'b0);
      src.idle();
      pop(8'h3C, 1'b1, 1'b1, 3'h6, 1'b1); // buffer number
      multistream_en <= 1'b0;
   endtask
   task automatic t_overrun();
      int i;
      fixed_block_length <= 12'h011;
      chk_bit(buffer_overrun, 1'b0, "early overrun");
      src.setup(1'b0, 3'h0);
      for (i = 0; i < 17; i++)
         src.wr(8'h10 + 8'(i), i == 0, 1'b0, 1'b0);
      src.idle();
      repeat (6) @(posedge clk);
      chk_bit(buffer_overrun, 1'b1, "no overrun");
      for (i = 0; i < 16; i++)
         pop(8'h10 + 8'(i), 1'b0, 1'b0, 3'h0, 1'b0);
      chk_bit(tx_valid, 1'b0, "fifo not empty");
   endtask
   task automatic t_serial();
      logic [7:0] q;
      logic [7:0] got;
      logic qm;
      int i;
      int j;
      int k;
      serial_mode <= 1'b1;
      fixed_block_length <= 12'h004;
      for (j = 0; j < 2; j++)
      begin
         lsb_first <= j[0];
         serial_marker_byte <= j[0];
         src.setup(1'b0, 3'h0);
         for (i = 0; i < 4; i++)
            src.wr(8'hC1 + 8'(i), i == 0, 1'b1, j[0]);
         src.idle();
         for (i = 0; i < 4; i++)
            pop(8'hC1 + 8'(i), i == 0, i == 3, 3'h0, 1'b1); // bit order
         src.setup(1'b1, 3'h0);
         push_n(4, 4);
         wait_hi(data_available_flag, "no serial flag");
         for (i = 0; i < 4; i++)
         begin
            for (k = 0; k < 8; k++)
            begin
               src.rd(q, qm);
               got[j[0] ? k : 7 - k] = q[0];
               chk_bit(qm, i == 0 && (j[0] || k == 0), "serial marker"); // marker length
            end
            chk_byte(got, 8'hA0 + 8'(i), "serial read byte"); // read bit order
         end
         src.idle();
      end
      serial_mode <= 1'b0;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      bad("timeout");
      final_report();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      chk_bit(byte_lane_oe_n, 1'b1, "reset oe");
      chk_bit(data_available_flag, 1'b0, "reset flag");
      chk_bit(tx_valid, 1'b0, "reset tx_valid");
      chk_bit(rx_ready, 1'b1, "reset rx_ready");
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_write(SDP_SYNC_COUNTER, 12'h003, 6'h02, 6'h3F, 6'h09, 6'h24);
      t_write(SDP_SYNC_LAST, 12'h003, 6'h22, 6'h3F, 6'h05, 6'h22); // varying
      t_write(SDP_SYNC_FIRST, 12'h004, 6'h21, 6'h2F, 6'h21, 6'h08); // first
      t_multi();
      fixed_block_length <= 12'h003;
      t_read(SDP_SYNC_COUNTER);
      t_read(SDP_SYNC_FIRST);
      t_read(SDP_SYNC_LAST);
      sync_mode <= SDP_SYNC_FIRST;
      t_overrun();
      t_serial();
      final_report();
   end
endmodule
